// ### rtl/cmdb_top.sv
/*
 * CPU address decoder with per-target wait timing, the work sram, flash
 * and core-space stores, the internal register page and the packet buffer
 * carved into five rings with post/used pointers and busy acknowledges.
 * Assumes one AHB-Lite master on hclk issuing single word transfers, and a
 * link/dma engine on hclk driving the ring port. ext_wait is asynchronous.
 */
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "cmdb_defines.svh"

module cmdb_top
   import cmdb_pkg::*;
#(
   parameter int FLASH_WORDS = 16384,
   parameter int CORE_WORDS  = 16
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output      logic          hreadyout,
   output      logic          hresp,
   output      logic [31:0]   hrdata,
   input  wire logic          ext_wait,
   input  wire cmdb_hw_req_t  hw_req,
   output      cmdb_hw_rsp_t  hw_rsp,
   input  wire logic          link_pkt_start,
   output      cmdb_busy_t    busy_code,
   output      logic          usb_active,
   input  wire logic          flash_prog_we,
   input  wire logic [13:0]   flash_prog_addr,
   input  wire logic [31:0]   flash_prog_data
);
   localparam int CW = $clog2(CORE_WORDS);

   // storage arrays; flash content arrives over the programming port
   logic [31:0]  sram_mem  [2048];
   logic [31:0]  buf_mem   [2048];
   logic [31:0]  core_mem  [CORE_WORDS];
   logic [31:0]  flash_mem [FLASH_WORDS];

   logic         hreadyout_r, hresp_r, dp_r, dp_write_r, dp_ext_r;
   logic [31:0]  hrdata_r;
   logic [23:0]  dp_addr_r;
   cmdb_region_t dp_reg_r;
   logic [1:0]   cnt_r;
   logic         ext_wait_m_r, ext_wait_s_r;
   logic [1:0]   ctrl_r;
   logic [13:0]  rxq_base_r, txh_base_r, txs_base_r, txs_lim_r, rxs_base_r;
   logic [8:0]   win_ptr_r;
   cmdb_hw_rsp_t hw_rsp_r;
   cmdb_busy_t   busy_code_r;
   logic         phase_r;
   logic [13:0]  post_r    [`CMDB_RING_COUNT];
   logic [13:0]  used_r    [`CMDB_RING_COUNT];
   logic [13:0]  ring_lo   [`CMDB_RING_COUNT];
   logic [13:0]  ring_hi   [`CMDB_RING_COUNT];
   logic [13:0]  ring_size [`CMDB_RING_COUNT];
   logic [13:0]  ring_occ  [`CMDB_RING_COUNT];
   logic [13:0]  ring_free [`CMDB_RING_COUNT];
   logic [`CMDB_RING_COUNT-1:0] post_wr, used_wr;

   function automatic cmdb_region_t region_of(input logic [31:0] a);
      if (a[31:24] != 8'h00)
         return rg_rsvd;
      if (a[23:0] <= `CMDB_SRAM_HI)
         return rg_sram;
      if (a[23:0] >= `CMDB_REGS_LO && a[23:0] <= `CMDB_REGS_HI)
         return rg_regs;
      if (a[23:0] >= `CMDB_BUF_LO && a[23:0] <= `CMDB_BUF_HI)
         return rg_buf;
      if (a[23:0] >= `CMDB_CORE_LO && a[23:0] <= `CMDB_CORE_HI)
         return rg_core;
      if (a[23:0] >= `CMDB_FLASH_LO && a[23:0] <= `CMDB_FLASH_HI)
         return rg_flash;
      return rg_rsvd;
   endfunction : region_of

   // advance a ring offset by one word, wrapping at the ring size
   function automatic logic [13:0] ring_step(input logic [13:0] off,
                                             input logic [13:0] size);
      logic [13:0] nx;
      nx = off + 14'h0004;
      return (nx >= size) ? 14'h0000 : nx;
   endfunction : ring_step

   // address phase decode and wait class of the new transfer
   wire          accept  = hsel & htrans[1] & hready;
   cmdb_region_t nw_reg;
   assign nw_reg = region_of(haddr);
   wire          nw_win  = (nw_reg == rg_regs) && (haddr[7:0] >= `CMDB_EXTW_LO)
                           && (haddr[7:0] <= `CMDB_EXTW_HI);
   wire          nw_ext  = nw_win | ((nw_reg == rg_buf) & ctrl_r[0]);
   wire [1:0]    nw_cnt  = (nw_reg == rg_buf) ? `CMDB_BUF_WAITS : 2'h0;
   wire          nw_zero = (nw_cnt == 2'h0) & ~nw_ext;
   wire          done    = dp_r & hreadyout_r;
   wire          wait_ok = ~(dp_ext_r & ext_wait_s_r);
   wire          finish  = dp_r & ~hreadyout_r & (cnt_r == 2'h0) & wait_ok;

   // read source: new zero-wait transfer, or the stalled one when it ends
   wire          load_rd   = (accept & nw_zero & ~hwrite) | (finish & ~dp_write_r);
   wire [23:0]   rd_addr   = accept ? haddr[23:0] : dp_addr_r;
   cmdb_region_t rd_reg;
   assign rd_reg = accept ? nw_reg : dp_reg_r;
   wire          reg_wr    = done & dp_write_r & (dp_reg_r == rg_regs);
   wire [7:0]    wr_off    = dp_addr_r[7:0];
   wire          win_wr    = reg_wr & (wr_off == `CMDB_WIN_DATA);
   wire          win_rd    = load_rd & (rd_reg == rg_regs) & (rd_addr[7:0] == `CMDB_WIN_DATA);
   wire [10:0]   win_idx   = 11'(`CMDB_USB_FIFO_LO >> 2) + 11'(win_ptr_r);
   // cpu writes any buffer word directly
   wire          cpu_buf_we = (done & dp_write_r & (dp_reg_r == rg_buf)) | win_wr;
   wire [10:0]   cpu_buf_ix = win_wr ? win_idx : dp_addr_r[12:2];
   // a zero-wait read right behind a write to the same word sees hwdata
   wire          fwd = done & dp_write_r & (dp_addr_r[23:2] == rd_addr[23:2])
                       & (rd_reg == dp_reg_r) & (rd_reg != rg_flash) & (rd_reg != rg_rsvd);

   // hardware regions fixed below the rings
   // stream rings are not checked for overlap
   // receive stream stops below the usb fifo while usb is active, else runs to the buffer top
   assign ring_lo[0] = `CMDB_HW_RES_END;
   assign ring_hi[0] = rxq_base_r;
   assign ring_lo[1] = rxq_base_r;
   assign ring_hi[1] = txh_base_r;
   assign ring_lo[2] = txh_base_r + `CMDB_TX_HDR_BYTES;
   assign ring_hi[2] = txs_base_r;
   assign ring_lo[3] = txs_base_r;
   assign ring_hi[3] = txs_lim_r;
   assign ring_lo[4] = rxs_base_r;
   assign ring_hi[4] = ctrl_r[0] ? `CMDB_USB_FIFO_LO : `CMDB_BUF_TOP;

   // hardware ring port: stream rings feed disk dma
   wire          ring_ok = hw_req.valid & (hw_req.ring < 3'(`CMDB_RING_COUNT));
   wire [2:0]    hw_r    = ring_ok ? hw_req.ring : 3'h0;
   wire [13:0]   hw_off  = hw_req.write ? post_r[hw_r] : used_r[hw_r];
   wire [13:0]   hw_addr = ring_lo[hw_r] + hw_off;
   // refuse a write into a full ring, a read from an empty one
   // cpu buffer writes take priority over hardware this cycle
   wire          hw_go   = ring_ok & ~cpu_buf_we & (hw_req.write
                           ? (ring_free[hw_r] >= 14'h0004) : (ring_occ[hw_r] != 14'h0000));

   // pointers, occupancy and free space of every ring
   genvar gi;
   generate
      for (gi = 0; gi < `CMDB_RING_COUNT; gi++) begin : g_ring
         localparam logic [7:0] POFF = `CMDB_PTR_BASE + 8'(8 * gi);
         assign ring_size[gi] = (ring_hi[gi] > ring_lo[gi]) ? ring_hi[gi] - ring_lo[gi] : 14'h0;
         assign ring_occ[gi]  = (post_r[gi] >= used_r[gi]) ? post_r[gi] - used_r[gi]
                                : ring_size[gi] - (used_r[gi] - post_r[gi]);
         // one word stays empty so that full and empty differ
         assign ring_free[gi] = (ring_size[gi] >= ring_occ[gi] + 14'h0004)
                                ? ring_size[gi] - ring_occ[gi] - 14'h0004 : 14'h0;
         assign post_wr[gi]   = reg_wr & (wr_off == POFF);
         assign used_wr[gi]   = reg_wr & (wr_off == POFF + 8'h04);
         // hardware steps wrap inside the ring; its step wins over software
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               post_r[gi] <= 14'h0;
               used_r[gi] <= 14'h0;
            end else begin
               if (hw_go & hw_req.write & (hw_r == 3'(gi)))
                  post_r[gi] <= ring_step(post_r[gi], ring_size[gi]);
               else if (post_wr[gi])
                  post_r[gi] <= {hwdata[13:2], 2'b00};
               if (hw_go & ~hw_req.write & (hw_r == 3'(gi)))
                  used_r[gi] <= ring_step(used_r[gi], ring_size[gi]);
               else if (used_wr[gi])
                  used_r[gi] <= {hwdata[13:2], 2'b00};
            end
         end
      end
   endgenerate

   // register page read mux; unused offsets read zero
   logic [31:0] reg_rd;
   always_comb begin
      reg_rd = 32'h0;
      case (rd_addr[7:0])
         `CMDB_CTRL:      reg_rd = {30'h0, ctrl_r};
         `CMDB_RXQ_BASE:  reg_rd = {18'h0, rxq_base_r};
         `CMDB_TXH_BASE:  reg_rd = {18'h0, txh_base_r};
         `CMDB_TXS_BASE:  reg_rd = {18'h0, txs_base_r};
         `CMDB_TXS_LIMIT: reg_rd = {18'h0, txs_lim_r};
         `CMDB_RXS_BASE:  reg_rd = {18'h0, rxs_base_r};
         `CMDB_WIN_DATA:  reg_rd = buf_mem[win_idx];
         `CMDB_WIN_PTR:   reg_rd = {23'h0, win_ptr_r};
         default: begin
            for (int i = 0; i < `CMDB_RING_COUNT; i++) begin
               if (rd_addr[7:0] == `CMDB_PTR_BASE + 8'(8 * i))
                  reg_rd = {18'h0, post_r[i]};
               if (rd_addr[7:0] == `CMDB_PTR_BASE + 8'(8 * i + 4))
                  reg_rd = {18'h0, used_r[i]};
               if (rd_addr[7:0] == `CMDB_FREE_BASE + 8'(4 * i))
                  reg_rd = {18'h0, ring_free[i]};
            end
         end
      endcase
   end

   // target read mux; reserved reads zero
   logic [31:0] rd_word;
   always_comb begin
      case (rd_reg)
         rg_sram:  rd_word = sram_mem[rd_addr[12:2]];
         rg_buf:   rd_word = buf_mem[rd_addr[12:2]];
         rg_regs:  rd_word = reg_rd;
         rg_core:  rd_word = core_mem[rd_addr[CW+1:2]];
         rg_flash: rd_word = flash_mem[rd_addr[15:2]];
         default:  rd_word = 32'h0;
      endcase
      if (fwd)
         rd_word = hwdata;
   end

   // ext_wait is a pin: two flops before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_wait_m_r <= 1'b0;
         ext_wait_s_r <= 1'b0;
      end else begin
         ext_wait_m_r <= ext_wait;
         ext_wait_s_r <= ext_wait_m_r;
      end
   end

   // bus timing; zero-wait targets keep hreadyout high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_r        <= 1'b0;
         dp_write_r  <= 1'b0;
         dp_ext_r    <= 1'b0;
         dp_addr_r   <= 24'h0;
         dp_reg_r    <= rg_rsvd;
         cnt_r       <= 2'h0;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end else if (accept) begin
         dp_r        <= 1'b1;
         dp_write_r  <= hwrite;
         dp_ext_r    <= nw_ext;
         dp_addr_r   <= haddr[23:0];
         dp_reg_r    <= nw_reg;
         cnt_r       <= nw_cnt;
         hreadyout_r <= nw_zero;
      end else if (done) begin
         dp_r <= 1'b0;
      end else if (dp_r & ~hreadyout_r) begin
         // count internal waits, then hold while external wait stands
         if (cnt_r != 2'h0)
            cnt_r <= cnt_r - 2'h1;
         else if (wait_ok)
            hreadyout_r <= 1'b1;
      end
   end

   // read data register, loaded in the cycle the answer becomes ready
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata_r <= 32'h0;
      else if (load_rd)
         hrdata_r <= rd_word;
   end

   // register page writes and the usb window pointer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r     <= `CMDB_CTRL_RST;
         rxq_base_r <= `CMDB_RXQ_RST;
         txh_base_r <= `CMDB_TXH_RST;
         txs_base_r <= `CMDB_TXS_RST;
         txs_lim_r  <= `CMDB_TXS_LIM_RST;
         rxs_base_r <= `CMDB_RXS_RST;
         win_ptr_r  <= 9'h0;
      end else begin
         if (reg_wr) begin
            case (wr_off)
               `CMDB_CTRL:      ctrl_r     <= hwdata[1:0];
               `CMDB_RXQ_BASE:  rxq_base_r <= {hwdata[13:2], 2'b00};
               `CMDB_TXH_BASE:  txh_base_r <= {hwdata[13:2], 2'b00};
               `CMDB_TXS_BASE:  txs_base_r <= {hwdata[13:2], 2'b00};
               `CMDB_TXS_LIMIT: txs_lim_r  <= {hwdata[13:2], 2'b00};
               `CMDB_RXS_BASE:  rxs_base_r <= {hwdata[13:2], 2'b00};
               default: ;
            endcase
         end
         // the window walks the usb fifo one word per data access
         if (reg_wr & (wr_off == `CMDB_WIN_PTR))
            win_ptr_r <= hwdata[8:0];
         else if (win_wr | win_rd)
            win_ptr_r <= win_ptr_r + 9'h1;
      end
   end

   // memory writes; flash and reserved ignore cpu writes
   always_ff @(posedge hclk) begin
      if (done & dp_write_r & (dp_reg_r == rg_sram))
         sram_mem[dp_addr_r[12:2]] <= hwdata;
      if (done & dp_write_r & (dp_reg_r == rg_core))
         core_mem[dp_addr_r[CW+1:2]] <= hwdata;
      if (flash_prog_we)
         flash_mem[flash_prog_addr] <= flash_prog_data;
      if (cpu_buf_we)
         buf_mem[cpu_buf_ix] <= hwdata;
      else if (hw_go & hw_req.write)
         buf_mem[hw_addr[12:2]] <= hw_req.wdata;
   end

   // ring port answer and busy acknowledge selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hw_rsp_r    <= '0;
         busy_code_r <= ack_ok;
         phase_r     <= 1'b0;
      end else begin
         hw_rsp_r.ack <= hw_go;
         if (hw_go & ~hw_req.write)
            hw_rsp_r.rdata <= buf_mem[hw_addr[12:2]];
         if (link_pkt_start) begin
            if ((ring_free[0] < `CMDB_RXH_NEED) | (ring_free[1] < `CMDB_RXQ_NEED)) begin
               busy_code_r <= ctrl_r[1] ? (phase_r ? busy_b : busy_a) : busy_x;
               phase_r     <= ~phase_r;
            end else begin
               busy_code_r <= ack_ok;
            end
         end
      end
   end

   assign hreadyout  = hreadyout_r;
   assign hresp      = hresp_r;
   assign hrdata     = hrdata_r;
   assign hw_rsp     = hw_rsp_r;
   assign busy_code  = busy_code_r;
   assign usb_active = ctrl_r[0];

   // buffer access timing: two stalled cycles, then ready
   sequence buf_stall_s;
      !hreadyout ##1 !hreadyout ##1 hreadyout;
   endsequence

   sram_zero_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      accept && nw_reg == rg_sram |=> hreadyout && dp_r)
      else $error("sram access stalled");
   flash_two_clk_a: assert property (@(posedge hclk) disable iff (!hresetn)
      accept && nw_reg == rg_flash |=> hreadyout)
      else $error("flash access stalled");
   core_zero_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      accept && nw_reg == rg_core |=> hreadyout)
      else $error("core space access stalled");
   buf_four_clk_a: assert property (@(posedge hclk) disable iff (!hresetn)
      accept && nw_reg == rg_buf && !ctrl_r[0] |=> buf_stall_s)
      else $error("buffer access not four clocks");
   reg_no_ext_a: assert property (@(posedge hclk) disable iff (!hresetn)
      accept && nw_reg == rg_regs && haddr[7:0] < `CMDB_EXTW_LO |=> hreadyout)
      else $error("plain register access stalled");
   ext_wait_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      dp_r && !hreadyout && dp_ext_r && cnt_r == 2'h0 && ext_wait_s_r |=> !hreadyout)
      else $error("external wait ignored");
   rsvd_read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      accept && nw_reg == rg_rsvd && !hwrite |=> hreadyout && hrdata == 32'h0)
      else $error("reserved read not zero in two clocks");
   ring_post_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hw_go && hw_req.write && hw_r == 3'h4 && !post_wr[4]
      |=> post_r[4] < ring_size[4] || ring_size[4] == 14'h0)
      else $error("receive stream post left its ring");
   busy_on_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
      link_pkt_start && ring_free[0] < `CMDB_RXH_NEED |=> busy_code != ack_ok)
      else $error("no busy with full header ring");
   usb_fifo_kept_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hw_go && hw_req.write && hw_r == 3'h4 && usb_active |-> hw_addr < `CMDB_USB_FIFO_LO)
      else $error("ring write into usb fifo");
   hw_ack_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hw_go |=> hw_rsp.ack ##1 (hw_rsp.ack == $past(hw_go)))
      else $error("ring port answer mistimed");
endmodule : cmdb_top

// ### rtl/cmdb_defines.svh
/*
 * Constants of the cpu map decoder and packet buffer rings: region bounds,
 * wait counts, buffer layout, register offsets and reset values.
 * Assumes a 24-bit cpu byte address space seen through an AHB-Lite slave.
 */
`ifndef CMDB_DEFINES_SVH
`define CMDB_DEFINES_SVH

// cpu address map, inclusive byte bounds
`define CMDB_SRAM_LO       24'h000000
`define CMDB_SRAM_HI       24'h001FFF
`define CMDB_REGS_LO       24'h002000
`define CMDB_REGS_HI       24'h0020FF
`define CMDB_BUF_LO        24'h010000
`define CMDB_BUF_HI        24'h011FFF
`define CMDB_CORE_LO       24'h030000
`define CMDB_CORE_HI       24'h05FFFF
`define CMDB_FLASH_LO      24'hC00000
`define CMDB_FLASH_HI      24'hC0FFFF

// data-phase wait counts; register page offsets that take the external wait
`define CMDB_BUF_WAITS     2'h1
`define CMDB_EXTW_LO       8'h70
`define CMDB_EXTW_HI       8'h7F

// packet buffer layout, byte offsets inside the 8KB buffer
`define CMDB_HW_RES_END    14'h0100
`define CMDB_TX_HDR_BYTES  14'h0040
`define CMDB_BUF_TOP       14'h2000
`define CMDB_USB_FIFO_LO   14'h1800
`define CMDB_RING_COUNT    5

// register page offsets
`define CMDB_CTRL          8'h00
`define CMDB_RXQ_BASE      8'h04
`define CMDB_TXH_BASE      8'h08
`define CMDB_TXS_BASE      8'h0C
`define CMDB_TXS_LIMIT     8'h10
`define CMDB_RXS_BASE      8'h14
`define CMDB_PTR_BASE      8'h20
`define CMDB_FREE_BASE     8'h50
`define CMDB_WIN_DATA      8'h70
`define CMDB_WIN_PTR       8'h74

// reset values
`define CMDB_CTRL_RST      2'h0
`define CMDB_RXQ_RST       14'h0400
`define CMDB_TXH_RST       14'h0800
`define CMDB_TXS_RST       14'h0900
`define CMDB_TXS_LIM_RST   14'h1000
`define CMDB_RXS_RST       14'h1000

// free space an incoming link packet needs in the receive header and queue rings
`define CMDB_RXH_NEED      14'h0020
`define CMDB_RXQ_NEED      14'h0020

`endif

// ### rtl/cmdb_pkg.sv
/*
 * Types of the cpu map decoder: target regions, link acknowledge codes and
 * the request/answer carriers of the hardware ring port.
 * Assumes cmdb_defines.svh for every number.
 */
package cmdb_pkg;
   // decoded target of one cpu access, one-hot
   typedef enum logic [5:0] {
      rg_sram  = 6'h01,
      rg_regs  = 6'h02,
      rg_buf   = 6'h04,
      rg_core  = 6'h08,
      rg_flash = 6'h10,
      rg_rsvd  = 6'h20
   } cmdb_region_t;

   // acknowledge sent back for an incoming link packet
   typedef enum logic [1:0] {
      ack_ok = 2'h0,
      busy_x = 2'h1,
      busy_a = 2'h2,
      busy_b = 2'h3
   } cmdb_busy_t;

   // link reception / disk dma request against one ring
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [2:0]  ring;
      logic [31:0] wdata;
   } cmdb_hw_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } cmdb_hw_rsp_t;
endpackage : cmdb_pkg

// ### bench/cmdb_cpu_master.sv
/*
 * Cpu-side bus master model: single word AHB-Lite transfers on request.
 * Assumes one slave whose hreadyout is looped back as hready.
 */
`timescale 1ns/1ps
module cmdb_cpu_master (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output      logic        hsel,
   output      logic [31:0] haddr,
   output      logic [1:0]  htrans,
   output      logic        hwrite,
   output      logic [2:0]  hsize,
   output      logic [31:0] hwdata
);
   // bus idle until a transfer is asked for
   initial begin
      hsel   = 1'h0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end

   // one transfer; n is clocks from address phase to completion edge
   task automatic xfer(input logic wr, input logic [31:0] a, wd,
                       output logic [31:0] rd, output int n);
      time t0;
      @(posedge hclk);
      t0 = $time;
      hsel   <= 1'h1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      // firmware waits out arbitration: request held until ready
      // ready and data are read at the rising edge, before its updates land
      do @(posedge hclk); while (hready !== 1'h1);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'h1);
      rd = hrdata;
      hwdata <= ~wd;  // released data no longer shows the old value
      haddr  <= ~a;
      n = int'(($time - t0) / 10);
   endtask : xfer
endmodule : cmdb_cpu_master

// ### bench/cmdb_top_tb_top.sv
/*
 * Self-checking bench of the cpu map decoder and packet buffer rings.
 * Assumes the cpu master model drives the bus; ring port driven here.
 */
`timescale 1ns/1ps
module cmdb_top_tb_top;
   import cmdb_pkg::*;
   logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_wait;
   logic         link_pkt_start, usb_active, flash_prog_we;
   logic [31:0]  haddr, hwdata, hrdata, flash_prog_data;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   logic [13:0]  flash_prog_addr;
   cmdb_hw_req_t hw_req;
   cmdb_hw_rsp_t hw_rsp;
   cmdb_busy_t   busy_code;
   int           n_mismatch = 0;
   int           total_checks = 0;

   cmdb_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .ext_wait(ext_wait), .hw_req(hw_req), .hw_rsp(hw_rsp),
      .link_pkt_start(link_pkt_start), .busy_code(busy_code),
      .usb_active(usb_active), .flash_prog_we(flash_prog_we),
      .flash_prog_addr(flash_prog_addr), .flash_prog_data(flash_prog_data));
   cmdb_cpu_master m_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // 100 MHz clock
   initial begin
      hclk = 1'h0;
      forever #5 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] g, e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic chk_n(input int g, lo, hi);
      total_checks++;
      if (g < lo || g > hi) begin
         n_mismatch++;
         $display("mismatch at %0t: took %0d clocks", $time, g);
      end
   endtask : chk_n

   // one bus access; reads compare data, every access its clock count
   task automatic acc(input logic wr, input logic [31:0] a, d, input int lo, hi);
      logic [31:0] rd;
      int          n;
      m_u.xfer(wr, a, d, rd, n);
      if (!wr) chk(rd, d);
      chk_n(n, lo, hi);
   endtask : acc

   // link packet start pulse, then the acknowledge choice
   task automatic pulse(input cmdb_busy_t e);
      @(posedge hclk);
      link_pkt_start <= 1'h1;
      @(posedge hclk);
      link_pkt_start <= 1'h0;
      @(posedge hclk);
      @(negedge hclk);
      chk({30'h0, busy_code}, {30'h0, e});
   endtask : pulse

   // one ring port request held for one cycle; ack looked at next cycle
   task automatic hw(input logic wr, input logic [2:0] r, input logic [31:0] d,
                     input logic ae);
      @(posedge hclk);
      hw_req <= '{1'h1, wr, r, d};
      @(posedge hclk);
      hw_req <= '{1'h0, 1'h0, 3'h0, ~d};
      @(negedge hclk);
      chk({31'h0, hw_rsp.ack}, {31'h0, ae});
      if (!wr && ae) chk(hw_rsp.rdata, d);
   endtask : hw

   task automatic t_mem;
      acc(1'h1, 32'h0000_0000, 32'hA5A5_0001, 2, 2);
      acc(1'h1, 32'h0000_1FFC, 32'h5A5A_0002, 2, 2);
      acc(1'h0, 32'h0000_1FFC, 32'h5A5A_0002, 2, 2);
      acc(1'h1, 32'h0001_0000, 32'h1234_0003, 4, 4);
      acc(1'h1, 32'h0001_1FFC, 32'h1234_0004, 4, 4);
      acc(1'h0, 32'h0001_0000, 32'h1234_0003, 4, 4);
      acc(1'h0, 32'h0001_1FFC, 32'h1234_0004, 4, 4);
      acc(1'h1, 32'h0003_0000, 32'hC0DE_0005, 2, 2);
      acc(1'h0, 32'h0003_0000, 32'hC0DE_0005, 2, 2);
      acc(1'h0, 32'h0000_0000, 32'hA5A5_0001, 2, 2);
      $display("test memories done");
   endtask : t_mem

   task automatic t_flash_rsvd;
      @(posedge hclk);
      flash_prog_we   <= 1'h1;
      flash_prog_addr <= 14'h3FFF;
      flash_prog_data <= 32'hF1A5_3FFF;
      @(posedge hclk);
      flash_prog_we <= 1'h0;
      acc(1'h1, 32'h00C0_FFFC, 32'h0, 2, 2);
      acc(1'h0, 32'h00C0_FFFC, 32'hF1A5_3FFF, 2, 2);
      acc(1'h1, 32'h0000_2100, 32'hFFFF_FFFF, 2, 2);
      acc(1'h0, 32'h0000_2100, 32'h0, 2, 2);
      acc(1'h0, 32'h0002_0000, 32'h0, 2, 2);
      acc(1'h0, 32'h0100_0000, 32'h0, 2, 2);
      chk({31'h0, hresp}, 32'h0);
      $display("test flash and reserved done");
   endtask : t_flash_rsvd

   task automatic t_wait;
      ext_wait <= 1'h1;
      acc(1'h0, 32'h0000_2004, 32'h0000_0400, 2, 2);
      acc(1'h0, 32'h0000_2010, 32'h0000_1000, 2, 2);
      fork
         acc(1'h1, 32'h0000_2074, 32'h0, 9, 16);
         begin
            repeat (8) @(posedge hclk);
            ext_wait <= 1'h0;
         end
      join
      acc(1'h0, 32'h0000_2074, 32'h0, 3, 5);
      $display("test waits done");
   endtask : t_wait

   task automatic t_ring;
      pulse(ack_ok);
      acc(1'h1, 32'h0000_2004, 32'h0000_0120, 2, 2);
      pulse(busy_x);
      acc(1'h1, 32'h0000_2000, 32'h0000_0002, 2, 2);
      // the busy_x answer already flipped the phase, so dual mode opens on b
      pulse(busy_b);
      pulse(busy_a);
      acc(1'h1, 32'h0000_2000, 32'h0, 2, 2);
      acc(1'h1, 32'h0000_2004, 32'h0000_0400, 2, 2);
      pulse(ack_ok);
      hw(1'h1, 3'h3, 32'hCAFE_0003, 1'h1);
      hw(1'h1, 3'h5, 32'hDEAD_0005, 1'h0);
      acc(1'h0, 32'h0000_2038, 32'h0000_0004, 2, 2);
      acc(1'h0, 32'h0001_0900, 32'hCAFE_0003, 4, 4);
      hw(1'h0, 3'h3, 32'hCAFE_0003, 1'h1);
      hw(1'h0, 3'h3, 32'h0, 1'h0);
      $display("test rings done");
   endtask : t_ring

   task automatic t_usb;
      acc(1'h1, 32'h0000_2000, 32'h0000_0001, 2, 2);
      @(negedge hclk);
      chk({31'h0, usb_active}, 32'h1);
      acc(1'h0, 32'h0001_0900, 32'hCAFE_0003, 4, 8);
      acc(1'h1, 32'h0000_2070, 32'h0B0B_0070, 3, 3);
      acc(1'h0, 32'h0001_1800, 32'h0B0B_0070, 4, 4);
      hw(1'h1, 3'h4, 32'hBEEF_0004, 1'h1);
      acc(1'h0, 32'h0001_1000, 32'hBEEF_0004, 4, 4);
      acc(1'h1, 32'h0000_2000, 32'h0, 2, 2);
      $display("test usb done");
   endtask : t_usb

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // hang guard, far beyond the couple of hundred clocks the tests need
   initial begin
      #200000;
      n_mismatch++;
      wrap_up();
   end

   // reset, then the scenarios in turn
   initial begin
      hresetn = 1'h0;
      ext_wait = 1'h0;
      link_pkt_start = 1'h0;
      flash_prog_we = 1'h0;
      flash_prog_addr = 14'h0;
      flash_prog_data = 32'h0;
      hw_req = '{1'h0, 1'h0, 3'h0, 32'h0};
      repeat (16) @(posedge hclk);
      hresetn <= 1'h1;
      @(negedge hclk);
      chk({31'h0, hreadyout}, 32'h1);
      t_mem();
      t_flash_rsvd();
      t_wait();
      t_ring();
      t_usb();
      wrap_up();
   end
endmodule : cmdb_top_tb_top
